// ===== design/bpcfg_top.sv
`timescale 1ns/1ns
module bpcfg_top (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Pack conditions from pins, asynchronous
	input wire logic charger_present,
	input wire logic load_present,
	input wire logic pack_cooled,
	input wire logic overtemperature_in,
	input wire logic thermistor_fault_in,
	input wire logic cell_voltage_fault_in,
	input wire logic open_cell_fault_in,
	input wire logic discharge_overcurrent_in,
	input wire logic discharge_short_circuit_in,
	input wire logic shutdown_request_in,
	input wire logic program_voltage_ok,
	// Outputs
	output logic low_dropout_regulator,
	output logic charge_fet_drive,
	output logic discharge_fet_drive,
	output logic temp_sense_active,
	output logic [5:0] overvoltage_trip_code,
	output logic [3:0] pack_cell_count,
	output logic irq
);
	import bpcfg_pkg::*;

	// ********************************
	// Input synchronisers
	// ********************************
	localparam int NSYNC = 11;
	logic [NSYNC-1:0] sync_a_r;
	logic [NSYNC-1:0] sync_b_r;
	wire [NSYNC-1:0] pins = {charger_present, load_present, pack_cooled, overtemperature_in,
		thermistor_fault_in, cell_voltage_fault_in, open_cell_fault_in,
		discharge_overcurrent_in, discharge_short_circuit_in, shutdown_request_in,
		program_voltage_ok};

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync_a_r <= '0;
			sync_b_r <= '0;
		end else begin
			sync_a_r <= pins;
			sync_b_r <= sync_a_r;
		end
	end

	// Only the second stage is read, so a metastable first stage never reaches logic
	logic charger_s;
	logic load_s;
	logic cool_s;
	logic hot_s;
	logic th_s;
	logic cv_s;
	logic oc_s;
	logic overcurrent_s;
	logic short_s;
	logic sdreq_s;
	logic pvok_s;
	assign {charger_s, load_s, cool_s, hot_s, th_s, cv_s, oc_s, overcurrent_s, short_s, sdreq_s,
		pvok_s} = sync_b_r;

	// ********************************
	// Configuration storage
	// ********************************
	// Index 0 of the array is system config; the access register sits apart.
	logic [7:0] nv_r [NUM_NV_REGS];
	logic [7:0] irq_status_r;
	logic [7:0] irq_mask_r;
	logic shutdown_cmd_r;

	function automatic logic [7:0] nv_mask(input int idx);
		case (idx)
			0: nv_mask = MASK_SYSTEM_CONFIG;
			1: nv_mask = MASK_OV_A;
			2: nv_mask = MASK_OV_B;
			3: nv_mask = MASK_UV_A;
			4: nv_mask = MASK_UV_B;
			5: nv_mask = MASK_OVERCURRENT_DELAY;
			6: nv_mask = MASK_SHORT_DELAY;
			default: nv_mask = MASK_FULL;
		endcase
	endfunction

	function automatic logic is_nv(input logic [3:0] a);
		is_nv = (a >= ADDR_SYSTEM_CONFIG) && (a <= ADDR_BALANCING_CONFIG);
	endfunction

	// A refused code still takes the other bits, so recovery settings are not lost
	wire bad_cell_wr = wr && (addr == ADDR_SYSTEM_CONFIG) &&
		(wdata[SYS_CELL_COUNT_MSB:SYS_CELL_COUNT_LSB] == CELL_CODE_INVALID);

	// Storage is not touched by mode changes, so settings persist.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_NV_REGS; gi++) begin : g_nv
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					nv_r[gi] <= NV_RESET_VALUE;
				end else if (wr && is_nv(addr) && (addr == 4'(gi + 1))) begin
					if (gi == 0) begin
						// Invalid cell code keeps the old field
						nv_r[gi] <= (bad_cell_wr ?
							{nv_r[gi][7:5], wdata[4:0]} : wdata) & nv_mask(gi);
					end else begin
						nv_r[gi] <= wdata & nv_mask(gi);
					end
				end
			end
		end
	endgenerate

	wire [7:0] system_config = nv_r[0];
	wire charger_thermal_disable = system_config[SYS_CHARGER_THERMAL_DISABLE];
	wire temp_en = system_config[SYS_TEMP_SENSE_ENABLE];
	wire overtemp_recovery_mode = system_config[SYS_OVERTEMP_RECOVERY_MODE];
	wire oc_rec_mode = system_config[SYS_OVERCURRENT_RECOVERY_MODE];

	// ********************************
	// Power mode
	// ********************************
	bpcfg_mode_t mode_r;
	logic th_latch_r;
	logic oc_latch_r;
	wire active = (mode_r == BPCFG_ACTIVE);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_r <= BPCFG_ACTIVE;
		end else begin
			case (mode_r)
				BPCFG_ACTIVE:
					if (sdreq_s || shutdown_cmd_r) begin
						mode_r <= BPCFG_SHUTDOWN;
					end
				// Nothing but the charger pin is watched in shutdown
				BPCFG_SHUTDOWN:
					if (charger_s) begin
						mode_r <= BPCFG_ACTIVE;
					end
				default: mode_r <= BPCFG_ACTIVE;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			shutdown_cmd_r <= 1'b0;
		end else begin
			shutdown_cmd_r <= wr && (addr == ADDR_COMMAND) && wdata[CMD_SHUTDOWN_BIT];
		end
	end

	// ********************************
	// Fault latches and recovery
	// ********************************
	// Thermal fault only seen while sensing is on and the pack is active.
	wire charger_clears = charger_thermal_disable && charger_s;
	wire th_seen = active && temp_en && (hot_s || th_s) && !charger_clears;
	// Charger clears first, ahead of the cool/load rule.
	wire th_recover = charger_clears || !temp_en ||
		(cool_s && !hot_s && !th_s && (!overtemp_recovery_mode || !load_s));

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			th_latch_r <= 1'b0;
		end else if (th_seen) begin
			th_latch_r <= 1'b1;
		end else if (th_recover) begin
			th_latch_r <= 1'b0;
		end
	end

	// Latched so a short pulse still holds the FETs off until the recovery condition
	wire oc_seen = active && (overcurrent_s || short_s);
	wire oc_recover = !overcurrent_s && !short_s && !load_s &&
		(!oc_rec_mode || charger_s);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			oc_latch_r <= 1'b0;
		end else if (oc_seen) begin
			oc_latch_r <= 1'b1;
		end else if (oc_recover) begin
			oc_latch_r <= 1'b0;
		end
	end

	// Faults hold the FETs off but never leave active mode by themselves.
	wire any_fault = th_latch_r || oc_latch_r || cv_s || oc_s;

	// ********************************
	// Outputs
	// ********************************
	// Regulator on through reset, so the pack logic keeps power while it starts
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			low_dropout_regulator <= 1'b1;
		end else begin
			low_dropout_regulator <= active;
		end
	end

	// Both drives off through reset until the fault latches are known
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			charge_fet_drive <= 1'b0;
			discharge_fet_drive <= 1'b0;
		end else begin
			charge_fet_drive <= active && !any_fault;
			discharge_fet_drive <= active && !any_fault;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			temp_sense_active <= 1'b0;
		end else begin
			temp_sense_active <= active && temp_en;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			overvoltage_trip_code <= '0;
		end else begin
			overvoltage_trip_code <= nv_r[1][5:0];
		end
	end

	// Code n gives ten minus n cells
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pack_cell_count <= '0;
		end else begin
			pack_cell_count <= CELL_COUNT_MAX -
				{1'b0, system_config[SYS_CELL_COUNT_MSB:SYS_CELL_COUNT_LSB]};
		end
	end

	// ********************************
	// Interrupts
	// ********************************
	logic mode_d_r;
	logic fault_d_r;
	// Idle level after reset matches active mode, so no false shutdown edge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_d_r <= 1'b0;
		end else begin
			mode_d_r <= !active;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fault_d_r <= 1'b0;
		end else begin
			fault_d_r <= any_fault;
		end
	end

	logic [IRQ_W-1:0] irq_event;
	always_comb begin
		irq_event = '0;
		irq_event[IRQ_SHUTDOWN] = !active && !mode_d_r;
		irq_event[IRQ_WAKE] = active && mode_d_r;
		irq_event[IRQ_FAULT] = any_fault && !fault_d_r;
		irq_event[IRQ_BAD_CELL_CODE] = bad_cell_wr;
	end

	wire [7:0] w1c = (wr && addr == ADDR_IRQ_STATUS) ? wdata : 8'h00;

	// Set wins over a clear in the same cycle.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_status_r <= 8'h00;
		end else begin
			irq_status_r <= (irq_status_r & ~w1c) | {{(8-IRQ_W){1'b0}}, irq_event};
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_mask_r <= 8'h00;
		end else if (wr && addr == ADDR_IRQ_MASK) begin
			irq_mask_r <= wdata & {{(8-IRQ_W){1'b0}}, {IRQ_W{1'b1}}};
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_r & irq_mask_r);
		end
	end

	// ********************************
	// Read port
	// ********************************
	// Mode status, read only: overcurrent latch, thermal latch, shutdown
	wire [7:0] mode_status = {5'h00, oc_latch_r, th_latch_r, !active};

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (rd) begin
			if (addr == ADDR_EEPROM_PROGRAM_CONTROL) begin
				rdata <= {7'h00, pvok_s};
			end else if (is_nv(addr)) begin
				rdata <= nv_r[addr - 4'h1];
			end else if (addr == ADDR_MODE_STATUS) begin
				rdata <= mode_status;
			end else if (addr == ADDR_IRQ_STATUS) begin
				rdata <= irq_status_r;
			end else if (addr == ADDR_IRQ_MASK) begin
				rdata <= irq_mask_r;
			end else begin
				rdata <= 8'h00;
			end
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule

// ===== design/bpcfg_pkg.sv
package bpcfg_pkg;
	// ********************************
	// Register map (byte index)
	// ********************************
	localparam logic [3:0] ADDR_EEPROM_PROGRAM_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_SYSTEM_CONFIG = 4'h1;
	localparam logic [3:0] ADDR_OVERVOLTAGE_CONFIG_A = 4'h2;
	localparam logic [3:0] ADDR_OVERVOLTAGE_CONFIG_B = 4'h3;
	localparam logic [3:0] ADDR_UNDERVOLTAGE_CONFIG_A = 4'h4;
	localparam logic [3:0] ADDR_UNDERVOLTAGE_CONFIG_B = 4'h5;
	localparam logic [3:0] ADDR_DISCHARGE_OVERCURRENT_DELAY = 4'h6;
	localparam logic [3:0] ADDR_SHORT_CIRCUIT_DELAY = 4'h7;
	localparam logic [3:0] ADDR_CURRENT_TRIP_LEVELS = 4'h8;
	localparam logic [3:0] ADDR_CHARGE_SHORT_CONFIG = 4'h9;
	localparam logic [3:0] ADDR_BALANCING_CONFIG = 4'hA;
	localparam logic [3:0] ADDR_MODE_STATUS = 4'hB;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'hC;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'hD;
	localparam logic [3:0] ADDR_COMMAND = 4'hE;
	localparam int NUM_NV_REGS = 10;
	// ********************************
	// Field positions
	// ********************************
	localparam int SYS_CELL_COUNT_MSB = 7;
	localparam int SYS_CELL_COUNT_LSB = 5;
	localparam int SYS_CHARGER_THERMAL_DISABLE = 4;
	localparam int SYS_TEMP_SENSE_ENABLE = 3;
	localparam int SYS_OVERTEMP_RECOVERY_MODE = 2;
	localparam int SYS_RESERVED_ZERO = 1;
	localparam int SYS_OVERCURRENT_RECOVERY_MODE = 0;
	localparam int PROG_VOLTAGE_OK_BIT = 0;
	localparam int CMD_SHUTDOWN_BIT = 0;
	// Writable bit masks per register; others are reserved, read zero
	localparam logic [7:0] MASK_SYSTEM_CONFIG = 8'hFD;
	localparam logic [7:0] MASK_OV_A = 8'h3F;
	localparam logic [7:0] MASK_OV_B = 8'hF7;
	localparam logic [7:0] MASK_UV_A = 8'h8F;
	localparam logic [7:0] MASK_UV_B = 8'hF7;
	localparam logic [7:0] MASK_OVERCURRENT_DELAY = 8'h1F;
	localparam logic [7:0] MASK_SHORT_DELAY = 8'h3F;
	localparam logic [7:0] MASK_FULL = 8'hFF;
	localparam logic [2:0] CELL_CODE_INVALID = 3'h7;
	localparam logic [3:0] CELL_COUNT_MAX = 4'hA;
	localparam logic [7:0] NV_RESET_VALUE = 8'h00;
	// Interrupt bits
	localparam int IRQ_SHUTDOWN = 0;
	localparam int IRQ_WAKE = 1;
	localparam int IRQ_FAULT = 2;
	localparam int IRQ_BAD_CELL_CODE = 3;
	localparam int IRQ_W = 4;
	typedef enum logic [0:0] {
		BPCFG_ACTIVE,
		BPCFG_SHUTDOWN
	} bpcfg_mode_t;
endpackage

// ===== tb/bpcfg_properties.sv
`timescale 1ns/1ns
module bpcfg_properties (
	input wire logic clock,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic charger_present,
	input wire logic low_dropout_regulator,
	input wire logic charge_fet_drive,
	input wire logic discharge_fet_drive,
	input wire logic temp_sense_active,
	input wire logic [5:0] overvoltage_trip_code,
	input wire logic [3:0] pack_cell_count
);
	import bpcfg_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	fet_needs_reg_a:
	assert property ((charge_fet_drive || discharge_fet_drive) |-> low_dropout_regulator) else $error("fet on in shutdown");
	sense_needs_reg_a:
	assert property (temp_sense_active |-> low_dropout_regulator) else $error("sensing in shutdown");
	charger_wakes_a:
	assert property (!low_dropout_regulator && charger_present |-> ##[1:6] low_dropout_regulator) else $error("no wake");
	cell_range_a:
	assert property (!$past(rst) |-> pack_cell_count inside {[4'h4:4'hA]}) else $error("cell count range");
	cell_decode_a:
	assert property (wr && addr == ADDR_SYSTEM_CONFIG && wdata[7:5] != CELL_CODE_INVALID |-> ##2
		pack_cell_count == CELL_COUNT_MAX - {1'b0, $past(wdata[7:5], 2)}) else $error("cell decode");
	bad_code_kept_a:
	assert property (wr && addr == ADDR_SYSTEM_CONFIG && wdata[7:5] == CELL_CODE_INVALID |-> ##2
		pack_cell_count == $past(pack_cell_count, 2)) else $error("bad code taken");
	ov_trip_a:
	assert property (wr && addr == ADDR_OVERVOLTAGE_CONFIG_A |-> ##2
		overvoltage_trip_code == $past(wdata[5:0], 2)) else $error("ov trip code");
	rdata_idle_a:
	assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
	sys_reserved_a:
	assert property ($past(rd) && $past(addr) == ADDR_SYSTEM_CONFIG |-> !rdata[SYS_RESERVED_ZERO])
		else $error("reserved bit set");
	cover property (wr && addr == ADDR_COMMAND);
	cover property ($fell(low_dropout_regulator));
	cover property ($rose(charge_fet_drive));
endmodule
bind bpcfg_top bpcfg_properties u_props (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .charger_present(charger_present),
	.low_dropout_regulator(low_dropout_regulator), .charge_fet_drive(charge_fet_drive),
	.discharge_fet_drive(discharge_fet_drive), .temp_sense_active(temp_sense_active),
	.overvoltage_trip_code(overvoltage_trip_code), .pack_cell_count(pack_cell_count));

// ===== tb/tb_bpcfg_top.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_bpcfg_top;
	import bpcfg_pkg::*;
	logic clock = 0, rst = 1, wr = 0, rd = 0, charger = 0, load = 0, cool = 0, hot = 0, th = 0;
	logic cvf = 0, ocf = 0, oc = 0, sc = 0, sdq = 0, pvok = 1;
	logic [3:0] addr = 0;
	logic [7:0] wdata = 0, rdata;
	logic reg_on, cfet, dfet, tsa, irq;
	logic [5:0] trip_code;
	logic [3:0] cells;
	logic [7:0] m [2:10] = '{MASK_OV_A, MASK_OV_B, MASK_UV_A, MASK_UV_B, MASK_OVERCURRENT_DELAY,
		MASK_SHORT_DELAY, MASK_FULL, MASK_FULL, MASK_FULL};
	int err_count = 0, compares = 0, cyc = 0;
	always #25 clock = ~clock;
	bpcfg_top dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .charger_present(charger), .load_present(load), .pack_cooled(cool),
		.overtemperature_in(hot), .thermistor_fault_in(th), .cell_voltage_fault_in(cvf),
		.open_cell_fault_in(ocf), .discharge_overcurrent_in(oc), .discharge_short_circuit_in(sc),
		.shutdown_request_in(sdq), .program_voltage_ok(pvok), .low_dropout_regulator(reg_on),
		.charge_fet_drive(cfet), .discharge_fet_drive(dfet), .temp_sense_active(tsa),
		.overvoltage_trip_code(trip_code), .pack_cell_count(cells), .irq(irq));
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1 `CHK("rdata", e, rdata)
		@(posedge clock);
	endtask
	// Pins pass two sync flops plus latch and output stages, so six cycles is ample
	task automatic st(input logic [3:0] e);
		repeat (6) @(posedge clock);
		#1 `CHK("fets reg sense", e, {cfet, dfet, reg_on, tsa})
		@(posedge clock);
	endtask
	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			stop_test;
		end
	end
	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		st(4'b1110);
		for (int a = 1; a <= 10; a++)
			rreg(a[3:0], NV_RESET_VALUE);
		rreg(ADDR_EEPROM_PROGRAM_CONTROL, 8'h01);
		rreg(4'hF, 8'h00);
		$display("reset test done");
		// Code 7 is refused, so the cell field keeps its old value
		wreg(ADDR_SYSTEM_CONFIG, 8'hFD);
		rreg(ADDR_SYSTEM_CONFIG, 8'h1D);
		for (int a = 2; a <= 10; a++) begin
			wreg(a[3:0], 8'hFF);
			rreg(a[3:0], m[a]);
		end
		// Pin low and a write of ones: the read-only bit must follow the pin
		pvok <= 1'b0;
		wreg(ADDR_EEPROM_PROGRAM_CONTROL, 8'hFF);
		rreg(ADDR_EEPROM_PROGRAM_CONTROL, 8'h00);
		for (int c = 0; c <= 6; c++) begin
			wreg(ADDR_SYSTEM_CONFIG, {c[2:0], 5'h00});
			repeat (2) @(posedge clock);
			#1 `CHK("cells", 4'hA - c[3:0], cells)
		end
		wreg(ADDR_OVERVOLTAGE_CONFIG_A, 8'hEA);
		rreg(ADDR_OVERVOLTAGE_CONFIG_A, 8'h2A);
		`CHK("trip code", 6'h2A, trip_code)
		rreg(ADDR_IRQ_STATUS, 8'h08);
		wreg(ADDR_IRQ_MASK, 8'h08);
		repeat (2) @(posedge clock);
		#1 `CHK("irq", 1'b1, irq)
		wreg(ADDR_IRQ_STATUS, 8'h08);
		repeat (2) @(posedge clock);
		#1 `CHK("irq", 1'b0, irq)
		wreg(ADDR_IRQ_MASK, 8'h00);
		$display("register test done");
		wreg(ADDR_COMMAND, 8'h01);
		st(4'b0000);
		rreg(ADDR_IRQ_STATUS, 8'h01);
		rreg(ADDR_MODE_STATUS, 8'h01);
		charger <= 1'b1;
		st(4'b1110);
		charger <= 1'b0;
		rreg(ADDR_IRQ_STATUS, 8'h03);
		rreg(ADDR_OVERVOLTAGE_CONFIG_A, 8'h2A);
		`CHK("cells", 4'h4, cells)
		sdq <= 1'b1;
		st(4'b0000);
		sdq <= 1'b0;
		st(4'b0000);
		charger <= 1'b1;
		st(4'b1110);
		charger <= 1'b0;
		cvf <= 1'b1;
		st(4'b0010);
		rreg(ADDR_IRQ_STATUS, 8'h07);
		cvf <= 1'b0;
		ocf <= 1'b1;
		st(4'b0010);
		ocf <= 1'b0;
		st(4'b1110);
		$display("mode test done");
		wreg(ADDR_SYSTEM_CONFIG, 8'h00);
		load <= 1'b1;
		oc <= 1'b1;
		st(4'b0010);
		rreg(ADDR_MODE_STATUS, 8'h04);
		oc <= 1'b0;
		st(4'b0010);
		load <= 1'b0;
		st(4'b1110);
		wreg(ADDR_SYSTEM_CONFIG, 8'h01);
		load <= 1'b1;
		sc <= 1'b1;
		st(4'b0010);
		sc <= 1'b0;
		load <= 1'b0;
		st(4'b0010);
		charger <= 1'b1;
		st(4'b1110);
		charger <= 1'b0;
		wreg(ADDR_SYSTEM_CONFIG, 8'h08);
		hot <= 1'b1;
		st(4'b0011);
		rreg(ADDR_MODE_STATUS, 8'h02);
		hot <= 1'b0;
		st(4'b0011);
		cool <= 1'b1;
		st(4'b1111);
		wreg(ADDR_SYSTEM_CONFIG, 8'h0C);
		load <= 1'b1;
		hot <= 1'b1;
		st(4'b0011);
		hot <= 1'b0;
		st(4'b0011);
		load <= 1'b0;
		st(4'b1111);
		cool <= 1'b0;
		wreg(ADDR_SYSTEM_CONFIG, 8'h1C);
		load <= 1'b1;
		th <= 1'b1;
		st(4'b0011);
		th <= 1'b0;
		st(4'b0011);
		charger <= 1'b1;
		st(4'b1111);
		charger <= 1'b0;
		load <= 1'b0;
		wreg(ADDR_SYSTEM_CONFIG, 8'h00);
		hot <= 1'b1;
		st(4'b1110);
		hot <= 1'b0;
		$display("recovery test done");
		stop_test;
	end
endmodule
